// ### hw/annp_pkg.sv
// Package: types, register indices, field positions and reset values of the next page registers
package annp_pkg;

   // ==========================================================
   // Next page word layout
   typedef struct packed
   {
      logic        next_page;
      logic        ack;
      logic        msg_page;
      logic        ack2;
      logic        toggle;
      logic [10:0] code;
   } annp_page_t;

   // ==========================================================
   // Bus geometry
   localparam int unsigned ANNP_ADDR_W = 12;
   localparam int unsigned ANNP_DATA_W = 32;
   localparam int unsigned ANNP_IDX_W  = 10;
   localparam int unsigned ANNP_REG_W  = 16;

   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [9:0] ANNP_IDX_EXP_STATUS  = 10'h006;
   localparam logic [9:0] ANNP_IDX_LOCAL_NP    = 10'h007;
   localparam logic [9:0] ANNP_IDX_PARTNER_NP  = 10'h008;
   localparam logic [9:0] ANNP_IDX_IRQ_STATUS  = 10'h010;
   localparam logic [9:0] ANNP_IDX_IRQ_MASK    = 10'h011;

   // ==========================================================
   // Field positions
   localparam int unsigned ANNP_BIT_NEXT_PAGE   = 15;
   localparam int unsigned ANNP_BIT_ACK         = 14;
   localparam int unsigned ANNP_BIT_MSG_PAGE    = 13;
   localparam int unsigned ANNP_BIT_ACK2        = 12;
   localparam int unsigned ANNP_BIT_TOGGLE      = 11;
   localparam int unsigned ANNP_BIT_EXP_PAGE_RX = 1;
   localparam int unsigned ANNP_BIT_EXP_NP_ABLE = 2;
   localparam int unsigned ANNP_BIT_IRQ_PAGE_RX = 0;
   localparam int unsigned ANNP_BIT_IRQ_PAGE_TX = 1;
   localparam int unsigned ANNP_IRQ_W           = 2;

   // ==========================================================
   // Reset values and write masks
   localparam logic [10:0] ANNP_CODE_RST        = 11'h000;
   localparam logic [15:0] ANNP_LOCAL_NP_RST    = 16'h2000;
   localparam logic [15:0] ANNP_PARTNER_NP_RST  = 16'h0000;
   localparam logic [15:0] ANNP_LOCAL_WR_MASK   = 16'hB7FF;
   localparam logic [1:0]  ANNP_IRQ_MASK_RST    = 2'h0;
   localparam logic [1:0]  ANNP_IRQ_STATUS_RST  = 2'h0;

   // Index to byte address
   function automatic logic [11:0] annp_byte_addr(input logic [9:0] idx);
      annp_byte_addr = {idx, 2'b00};
   endfunction

endpackage

// ### hw/annp_irq.sv
// Sticky event status, mask and level interrupt for the next page registers
`timescale 1ns/1ps
`default_nettype none
module annp_irq
   import annp_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic [ANNP_IRQ_W-1:0] event_set,
   input  wire logic [ANNP_IRQ_W-1:0] status_clr,
   input  wire logic                  mask_wr,
   input  wire logic [ANNP_IRQ_W-1:0] mask_wdata,
   output var  logic [ANNP_IRQ_W-1:0] status,
   output var  logic [ANNP_IRQ_W-1:0] mask,
   output var  logic                  irq
);

   // ==========================================================
   // Next values
   logic [ANNP_IRQ_W-1:0] next_status;
   logic [ANNP_IRQ_W-1:0] next_mask;

   // Set wins over clear so an event landing on the clearing read is kept
   assign next_status = (status & ~status_clr) | event_set;
   assign next_mask   = mask_wr ? mask_wdata : mask;

   // ==========================================================
   // State
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         status <= ANNP_IRQ_STATUS_RST;
         mask   <= ANNP_IRQ_MASK_RST;
         irq    <= 1'b0;
      end
      else
      begin
         status <= next_status;
         mask   <= next_mask;
         irq    <= |(next_status & next_mask);
      end
   end

endmodule
`default_nettype wire

// ### hw/annp_regs.sv
// Auto-negotiation next page register pair with expansion status over APB
//
// Notes on behaviour
// - Local bit 15 writable; set advertises further next pages follow.
// - Local bit 13 writable, resets to 1; 1 message page, 0 unformatted.
// - Local bit 12 writable compliance flag; 1 will comply, 0 cannot.
// - Local bit 11 read-only, inverse of toggle in last exchanged word.
// - Local bits 10:0 writable outgoing code field, meaning set by bit 13.
// - Local code field resets to the null page encoding.
// - Partner register read-only, reset zero, captures received flags 15 to 11.
// - Partner bits 10:0 show the received code field.
// - Expansion page received bit latches on new page, holds until read.
// - Expansion bit 2 reads 1, local device can exchange next pages.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module annp_regs
   import annp_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ANNP_ADDR_W-1:0] paddr,
   input  wire logic [ANNP_DATA_W-1:0] pwdata,
   output var  logic [ANNP_DATA_W-1:0] prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   // Line side, auto-negotiation arbitration on the same clock
   input  wire logic                   rx_page_valid,
   input  wire annp_page_t             rx_page,
   input  wire logic                   tx_page_done,
   output var  annp_page_t             tx_page,
   // Interrupt
   output var  logic                   irq
);

   // ==========================================================
   // Register state
   annp_page_t            local_np;
   annp_page_t            partner_np;
   logic                  exp_page_rx;
   logic [ANNP_IRQ_W-1:0] irq_status;
   logic [ANNP_IRQ_W-1:0] irq_mask;
   logic                  irq_line;

   // Read capture, kept so a read only clears what it reported
   logic [ANNP_REG_W-1:0] rd_capture;
   logic                  rd_hit_exp;
   logic                  rd_hit_irq;

   // ==========================================================
   // Bus phase decode
   wire                   bus_setup;
   wire                   bus_done;
   wire                   bus_wr_done;
   wire                   bus_rd_done;

   assign bus_setup   = psel & ~penable;
   assign bus_done    = psel & penable & pready;
   assign bus_wr_done = bus_done & pwrite & ~pslverr;
   assign bus_rd_done = bus_done & ~pwrite & ~pslverr;

   // ==========================================================
   // Address decode
   wire                   hit_exp;
   wire                   hit_local;
   wire                   hit_partner;
   wire                   hit_irq_status;
   wire                   hit_irq_mask;
   wire                   hit_any;

   assign hit_exp        = (paddr == annp_byte_addr(ANNP_IDX_EXP_STATUS));
   assign hit_local      = (paddr == annp_byte_addr(ANNP_IDX_LOCAL_NP));
   assign hit_partner    = (paddr == annp_byte_addr(ANNP_IDX_PARTNER_NP));
   assign hit_irq_status = (paddr == annp_byte_addr(ANNP_IDX_IRQ_STATUS));
   assign hit_irq_mask   = (paddr == annp_byte_addr(ANNP_IDX_IRQ_MASK));
   assign hit_any        = hit_exp | hit_local | hit_partner | hit_irq_status | hit_irq_mask;

   // ==========================================================
   // Register read views
   wire [ANNP_REG_W-1:0]  exp_view;
   wire [ANNP_REG_W-1:0]  local_view;
   wire [ANNP_REG_W-1:0]  partner_view;
   wire [ANNP_REG_W-1:0]  irq_status_view;
   wire [ANNP_REG_W-1:0]  irq_mask_view;

   // Reserved bits 14 reads zero, toggle shows the flip-flop
   assign local_view = {local_np.next_page, 1'b0, local_np.msg_page, local_np.ack2,
                        local_np.toggle, local_np.code};

   // Whole word read-only, flags and code as received
   assign partner_view = partner_np;

   // Ability bit is a constant one
   assign exp_view = ANNP_REG_W'((1 << ANNP_BIT_EXP_NP_ABLE)
                     | (32'(exp_page_rx) << ANNP_BIT_EXP_PAGE_RX));

   // Interrupt words sit in the low bits, the rest read zero
   function automatic logic [ANNP_REG_W-1:0] irq_word(input logic [ANNP_IRQ_W-1:0] bits);
      irq_word = {{(ANNP_REG_W-ANNP_IRQ_W){1'b0}}, bits};
   endfunction

   assign irq_status_view = irq_word(irq_status);
   assign irq_mask_view   = irq_word(irq_mask);

   // ==========================================================
   // Read select
   logic [ANNP_REG_W-1:0] rd_select;

   always_comb
   begin
      rd_select = '0;
      if (hit_exp)
      begin
         rd_select = exp_view;
      end
      else if (hit_local)
      begin
         rd_select = local_view;
      end
      else if (hit_partner)
      begin
         rd_select = partner_view;
      end
      else if (hit_irq_status)
      begin
         rd_select = irq_status_view;
      end
      else if (hit_irq_mask)
      begin
         rd_select = irq_mask_view;
      end
   end

   // ==========================================================
   // APB response, no wait state, answered in the first access cycle
   logic                   next_pready;
   logic                   next_pslverr;
   logic [ANNP_DATA_W-1:0] next_prdata;

   assign next_pready  = bus_setup;
   assign next_pslverr = bus_setup ? ~hit_any : (pslverr & ~bus_done);
   assign next_prdata  = (bus_setup & ~pwrite & hit_any) ? {16'h0000, rd_select}
                       : prdata;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= next_pready;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end
   end

   // Remember what a read reported and where it pointed
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_capture <= 16'h0000;
         rd_hit_exp <= 1'b0;
         rd_hit_irq <= 1'b0;
      end
      else if (bus_setup)
      begin
         rd_capture <= rd_select;
         rd_hit_exp <= hit_exp & ~pwrite;
         rd_hit_irq <= hit_irq_status & ~pwrite;
      end
   end

   // ==========================================================
   // Local next page register
   wire                   local_wr;
   wire [ANNP_REG_W-1:0]  local_wdata;
   annp_page_t            next_local_np;

   assign local_wr    = bus_wr_done & hit_local;
   assign local_wdata = pwdata[ANNP_REG_W-1:0] & ANNP_LOCAL_WR_MASK;

   always_comb
   begin
      next_local_np = local_np;
      if (local_wr)
      begin
         next_local_np.next_page = local_wdata[ANNP_BIT_NEXT_PAGE];
         next_local_np.msg_page  = local_wdata[ANNP_BIT_MSG_PAGE];
         next_local_np.ack2      = local_wdata[ANNP_BIT_ACK2];
         next_local_np.code      = local_wdata[10:0];
      end
      // After each exchanged word the next one carries the opposite toggle
      if (tx_page_done)
      begin
         next_local_np.toggle = ~local_np.toggle;
      end
      // Bit 14 is reserved on the local side and never sent as set
      next_local_np.ack = 1'b0;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         local_np <= annp_page_t'(ANNP_LOCAL_NP_RST);
      end
      else
      begin
         local_np <= next_local_np;
      end
   end

   // Line sees the register contents directly
   assign tx_page = local_np;

   // ==========================================================
   // Partner next page register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         partner_np <= annp_page_t'(ANNP_PARTNER_NP_RST);
      end
      else if (rx_page_valid)
      begin
         partner_np <= rx_page;
      end
   end

   // ==========================================================
   // Expansion status, page received latches high
   wire                   exp_clr;
   logic                  next_exp_page_rx;

   // Only a completed read that reported the bit may clear it
   assign exp_clr          = bus_rd_done & rd_hit_exp & rd_capture[ANNP_BIT_EXP_PAGE_RX];
   assign next_exp_page_rx = rx_page_valid | (exp_page_rx & ~exp_clr);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         exp_page_rx <= 1'b0;
      end
      else
      begin
         exp_page_rx <= next_exp_page_rx;
      end
   end

   // ==========================================================
   // Interrupt events
   wire [ANNP_IRQ_W-1:0]  irq_events;
   wire [ANNP_IRQ_W-1:0]  irq_clr;
   wire                   irq_mask_wr;

   assign irq_events  = {tx_page_done, rx_page_valid};
   assign irq_clr     = (bus_rd_done & rd_hit_irq) ? rd_capture[ANNP_IRQ_W-1:0]
                      : {ANNP_IRQ_W{1'b0}};
   assign irq_mask_wr = bus_wr_done & hit_irq_mask;

   annp_irq u_irq
   (
      .clk        (clk),
      .resetn     (resetn),
      .event_set  (irq_events),
      .status_clr (irq_clr),
      .mask_wr    (irq_mask_wr),
      .mask_wdata (pwdata[ANNP_IRQ_W-1:0]),
      .status     (irq_status),
      .mask       (irq_mask),
      .irq        (irq_line)
   );

   assign irq = irq_line;

endmodule
`default_nettype wire

// ### verification/annp_chk.sv
// Checker: assertions on the next page register block ports
`timescale 1ns/1ps
`default_nettype none
module annp_chk
   import annp_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   resetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [ANNP_ADDR_W-1:0] paddr,
   input wire logic [ANNP_DATA_W-1:0] pwdata,
   input wire logic [ANNP_DATA_W-1:0] prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   rx_page_valid,
   input wire annp_page_t             rx_page,
   input wire logic                   tx_page_done,
   input wire annp_page_t             tx_page,
   input wire logic                   irq
);
   // ==========================================
   // Helpers
   logic [15:0] last_rx;
   wire logic done = psel && penable && pready;
   wire logic wr_loc = done && pwrite && paddr == 12'h01C;
   wire logic rd_par = done && !pwrite && paddr == 12'h020;
   wire logic [13:0] loc_f = {tx_page.next_page, tx_page.msg_page, tx_page.ack2, tx_page.code};
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         last_rx <= 16'h0000;
      else if (rx_page_valid)
         last_rx <= rx_page;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Assertions
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   reset_page_a: assert property ($rose(resetn) |-> tx_page == 16'h2000)
      else $error("local page reset value wrong");
   local_write_a: assert property (
      wr_loc |=> loc_f == $past({pwdata[15], pwdata[13:12], pwdata[10:0]}))
      else $error("local page write lost");
   local_hold_a: assert property (!wr_loc |=> $stable(loc_f))
      else $error("local page changed without write");
   toggle_track_a: assert property (
      1'b1 |=> tx_page.toggle == ($past(tx_page.toggle) ^ $past(tx_page_done)))
      else $error("toggle not inverted on exchange");
   partner_read_a: assert property (
      rd_par && !$past(rx_page_valid) && !$past(rx_page_valid, 2) |-> prdata[15:0] == last_rx)
      else $error("partner page read wrong");
   irq_cause_a: assert property (
      $rose(irq) |-> $past(rx_page_valid || tx_page_done || (psel && pwrite), 1)
      || $past(rx_page_valid || tx_page_done, 2))
      else $error("interrupt without cause");
   cover property (wr_loc);
   cover property (rd_par);
   cover property ($rose(irq));
endmodule
bind annp_regs annp_chk chk_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_page_valid(rx_page_valid), .rx_page(rx_page),
   .tx_page_done(tx_page_done), .tx_page(tx_page), .irq(irq));
`default_nettype wire

// ### verification/annp_lp.sv
// Link partner model: swaps one next page per exchange
`timescale 1ns/1ps
`default_nettype none
module annp_lp
   import annp_pkg::*;
(
   input  wire logic       clk,
   input  wire annp_page_t tx_page,
   output var  logic       rx_page_valid,
   output var  annp_page_t rx_page,
   output var  logic       tx_page_done
);
   // ==========================================
   // Exchange, after an optional stall
   annp_page_t seen_tx;
   initial
   begin
      rx_page_valid = 1'b0;
      tx_page_done = 1'b0;
      rx_page = 16'h0000;
   end
   task automatic exchange(input annp_page_t p, input int stall);
      repeat (stall) @(posedge clk);
      @(posedge clk);
      rx_page_valid <= 1'b1;
      rx_page <= p;
      tx_page_done <= 1'b1;
      seen_tx <= tx_page;
      @(posedge clk);
      rx_page_valid <= 1'b0;
      tx_page_done <= 1'b0;
      // Stale data must not look valid
      rx_page <= ~p;
   endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Testbench: register access, page exchange and interrupt checks
`timescale 1ns/1ps
`default_nettype none
module tb
   import annp_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rdv;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        rx_page_valid;
   logic        tx_page_done;
   logic        irq;
   annp_page_t  rx_page;
   annp_page_t  tx_page;
   int          fails = 0;
   int          cmp_count = 0;
   always #12.5 clk = ~clk;
   annp_regs dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_page_valid(rx_page_valid), .rx_page(rx_page),
      .tx_page_done(tx_page_done), .tx_page(tx_page), .irq(irq));
   annp_lp lp_u (.clk(clk), .tx_page(tx_page), .rx_page_valid(rx_page_valid),
      .rx_page(rx_page), .tx_page_done(tx_page_done));
   // ==========================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No wait limit here: only the watchdog ends a hung transfer
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rdv, exp);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial
   begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd(12'h01C, 32'h00002000);
      rd(12'h020, 32'h00000000);
      rd(12'h018, 32'h00000004);
      rd(12'h044, 32'h00000000);
      apb(1'b1, 12'h01C, 32'hFFFFFFFF);
      rd(12'h01C, 32'h0000B7FF);
      apb(1'b1, 12'h01C, 32'h00000000);
      rd(12'h01C, 32'h00000000);
      apb(1'b1, 12'h020, 32'h0000FFFF);
      check({31'h0, err}, 32'h0);
      rd(12'h020, 32'h00000000);
      apb(1'b0, 12'h3FC, 32'h00000000);
      check({31'h0, err}, 32'h1);
      apb(1'b1, 12'h044, 32'h00000001);
      rd(12'h044, 32'h00000001);
      apb(1'b1, 12'h01C, 32'h00008123);
      lp_u.exchange(16'hA5A5, 0);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      check({16'h0, lp_u.seen_tx}, 32'h8123);
      rd(12'h018, 32'h00000006);
      rd(12'h018, 32'h00000004);
      rd(12'h020, 32'h0000A5A5);
      rd(12'h01C, 32'h00008923);
      rd(12'h040, 32'h00000003);
      rd(12'h040, 32'h00000000);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h044, 32'h00000000);
      lp_u.exchange(16'h5A5A, 4);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      rd(12'h020, 32'h00005A5A);
      rd(12'h01C, 32'h00008123);
      rd(12'h040, 32'h00000003);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(12'h01C, 32'h00002000);
      rd(12'h020, 32'h00000000);
      give_verdict;
   end
   // Generous bound: the tests need under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge clk);
      fails++;
      give_verdict;
   end
endmodule
`default_nettype wire
